// file: design/pie_map_pkg.sv
// Package: constants and carriers for the interrupt vector mapping block
// Summary of operation
// - Sources form twelve groups of eight, each group on one CPU line.
// - Of 96 source positions, 45 are wired and the rest are reserved.
// - Reserved positions have no hardware source; only software sets them.
// - An enabled reserved flag set by software is delivered as a request.
// - The reset vector never comes from the vector table.
// - Each wired source goes to its fixed group and position.
// - With fetch enable set, non-reset vectors come from the table.
// - Bits 15 to 1 of the last vector address fetched from the table are kept.
package pie_map_pkg;
    localparam int NUM_GROUPS = 12;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_SOURCES = 96;
    localparam int NUM_WIRED = 45;
    localparam logic [15:0] TABLE_BASE = 16'h0d00;
    localparam logic [6:0] FIRST_ID = 7'h20;
    localparam logic [15:0] ADDR_MASK = 16'hfffe;
    localparam logic [14:0] VECT_RESET = 15'h0000;
    // One byte per group, group one in the low byte
    localparam logic [95:0] WIRED_MASK = 96'h0000_003f_0000_337f_7f7f_7ffb;
    // Fetched vector description handed to the CPU
    typedef struct packed {
        logic valid;
        logic from_table;
        logic [15:0] addr;
    } vec_fetch_t;
endpackage

// file: design/pie_vector_group_mapping.sv
// Module: twelve-group interrupt expander with vector addressing
`timescale 1ns/10ps
module pie_vector_group_mapping #(
    parameter int NUM_GROUPS = 12
) (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Synchronous reset, low
    input wire logic [95:0] src_irq_i, // Source requests, bit 8g+p
    input wire logic [95:0] enable_i, // Per-position enables
    input wire logic [95:0] sw_set_i, // Software flag set pulses
    input wire logic [95:0] sw_clr_i, // Software flag clear pulses
    input wire logic vector_fetch_enable_i, // Table fetch enable
    input wire logic ack_i, // CPU takes a vector this cycle
    input wire logic [3:0] ack_line_i, // CPU line being acknowledged
    input wire logic reset_fetch_i, // CPU fetching reset vector
    output logic [11:0] cpu_irq_o, // One line per group
    output logic [95:0] group_flag_register_o, // Flag state
    output pie_map_pkg::vec_fetch_t fetch_o, // Fetched vector
    output logic [14:0] last_vector_address_o // Bits 15..1 last table fetch
);
    // -----------------------------------------------------------
    // Flag storage
    // -----------------------------------------------------------
    logic [95:0] flag_r;
    logic [95:0] flag_nxt;
    logic [95:0] hw_req;
    logic [11:0] line_r;
    logic [11:0] line_nxt;
    pie_map_pkg::vec_fetch_t fetch_r;
    pie_map_pkg::vec_fetch_t fetch_nxt;
    logic [14:0] last_r;
    logic [14:0] last_nxt;
    logic [95:0] take_bit;
    logic [2:0] win_pos;
    logic [6:0] win_idx;
    logic win_any;
    logic [6:0] slot_id; // Vector id of the winner

    // Flags are plain set/clear bits; the enable and acknowledge
    // registers that software sees live outside this block, so
    // the enables arrive here as levels and are never stored.
    // Reserved positions are masked off so only software sets them
    // wired only
    assign hw_req = src_irq_i & pie_map_pkg::WIRED_MASK;
    // Set wins over clear so no event is lost in a clear cycle
    // software set delivered
    assign flag_nxt = (flag_r & ~sw_clr_i & ~take_bit) | hw_req | sw_set_i;

    // Highest priority pending position in a group: lowest index
    function automatic logic [3:0] pick(input logic [7:0] pend);
        logic [3:0] res;
        res = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (pend[i]) begin
                res = 4'(i);
            end
        end
        return res;
    endfunction

    // -----------------------------------------------------------
    // Group lines
    // -----------------------------------------------------------
    // eight per line
    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_line
            assign line_nxt[g] = |(flag_r[g*8 +: 8] & enable_i[g*8 +: 8]);
        end
    endgenerate

    logic [3:0] pick_res;
    logic [7:0] ack_pend;
    assign ack_pend = (ack_line_i < 4'(NUM_GROUPS)) ?
        (flag_r[ack_line_i*8 +: 8] & enable_i[ack_line_i*8 +: 8]) : 8'h00;
    assign pick_res = pick(ack_pend);
    assign win_any = ack_i && !reset_fetch_i && !pick_res[3];
    assign win_pos = pick_res[2:0];
    assign win_idx = 7'({ack_line_i, win_pos});
    assign take_bit = (win_any && vector_fetch_enable_i) ?
        (96'h1 << win_idx) : 96'h0;

    // slot address, enable, reset never from table
    assign fetch_nxt.valid = ack_i;
    assign fetch_nxt.from_table = win_any && vector_fetch_enable_i;
    // Slot word address is the base plus twice the vector id; ids
    // stay below 128, so the doubled id never carries past bit 7
    assign slot_id = 7'(pie_map_pkg::FIRST_ID + win_idx);
    assign fetch_nxt.addr = fetch_nxt.from_table ?
        (pie_map_pkg::TABLE_BASE + 16'({slot_id, 1'b0})) : 16'h0000;
    assign last_nxt = fetch_nxt.from_table ? fetch_nxt.addr[15:1] : last_r;

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_r <= '0;
            line_r <= '0;
            fetch_r <= '0;
            last_r <= pie_map_pkg::VECT_RESET;
        end else begin
            flag_r <= flag_nxt;
            line_r <= line_nxt;
            fetch_r <= fetch_nxt;
            last_r <= last_nxt;
        end
    end

    assign cpu_irq_o = line_r;
    assign group_flag_register_o = flag_r;
    assign fetch_o = fetch_r;
    assign last_vector_address_o = last_r;

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    // All checks share the system clock and hold off during reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_RESERVED_QUIET: assert property (
        (sw_set_i == 96'h0) |=> ((flag_r & ~$past(flag_r) &
        ~pie_map_pkg::WIRED_MASK) == 96'h0))
        else $error("Reserved flag rose without software");

    AST_WIRED_SET: assert property (
        ((src_irq_i & pie_map_pkg::WIRED_MASK) != 96'h0) |=>
        ((flag_r & $past(src_irq_i) & pie_map_pkg::WIRED_MASK) ==
        ($past(src_irq_i) & pie_map_pkg::WIRED_MASK)))
        else $error("Wired request not latched");

    AST_RESET_NOT_TABLE: assert property (
        (ack_i && reset_fetch_i) |=> !fetch_r.from_table)
        else $error("Reset vector came from table");

    AST_DISABLED_DEFAULT: assert property (
        !vector_fetch_enable_i |=> !fetch_r.from_table)
        else $error("Table used while disabled");

    AST_FETCH_VALID: assert property (
        ack_i |=> fetch_r.valid)
        else $error("Fetch not answered");

    AST_SLOT_RANGE: assert property (
        fetch_r.from_table |-> (fetch_r.addr >= 16'h0d40 &&
        fetch_r.addr <= 16'h0dfe && !fetch_r.addr[0]))
        else $error("Vector slot address out of range");

    AST_SLOT_INDEX: assert property (
        (win_any && vector_fetch_enable_i) |=>
        (fetch_r.addr[5:1] == 5'($past(win_idx))))
        else $error("Vector slot does not match winner");

    AST_PRIO_FIRST: assert property (
        win_any |-> ((ack_pend & ((8'h01 << win_pos) - 8'h01)) == 8'h00))
        else $error("Lower position left pending");

    AST_PRIO_PEND: assert property (
        win_any |-> ack_pend[win_pos])
        else $error("Winner not pending");

    AST_LAST_ADDR: assert property (
        fetch_r.from_table |-> last_r == fetch_r.addr[15:1])
        else $error("Last vector address not captured");

    AST_LAST_HOLD: assert property (
        !fetch_nxt.from_table |=> $stable(last_r))
        else $error("Last vector address moved");

    AST_LINE: assert property (
        ((flag_r[71:64] & enable_i[71:64]) != 8'h0) |=> cpu_irq_o[8])
        else $error("Group line not raised");

    generate
        for (g = 0; g < 12; g++) begin : g_chk
            AST_LINE_UP: assert property (
                (|(flag_r[g*8 +: 8] & enable_i[g*8 +: 8]))
                |=> cpu_irq_o[g])
                else $error("Group line not raised");
            AST_LINE_DOWN: assert property (
                !(|(flag_r[g*8 +: 8] & enable_i[g*8 +: 8]))
                |=> !cpu_irq_o[g])
                else $error("Group line raised while idle");
        end
    endgenerate

    AST_SW_SET: assert property (
        sw_set_i[95] |=> flag_r[95])
        else $error("Software set lost");

    AST_TAKE_CLEARS: assert property (
        (win_any && vector_fetch_enable_i && !sw_set_i[win_idx] &&
        !hw_req[win_idx]) |=> !flag_r[$past(win_idx)])
        else $error("Taken flag not cleared");

    AST_HW_ROUTE: assert property (
        src_irq_i[64] |=> flag_r[64])
        else $error("Serial receive not routed");
    AST_CAN_ROUTE: assert property (
        src_irq_i[69] |=> flag_r[69])
        else $error("CAN line not routed");
endmodule

// file: sim/cpu_model.sv
// CPU stand-in that takes vectors for raised lines
`timescale 1ns/10ps
module cpu_model (
    input wire logic clk_i, // System clock
    input wire logic [11:0] cpu_irq_i, // Raised lines
    input wire logic run_i, // Line fetches allowed; reset vector fetches ignore it
    input wire logic boot_i, // Reset vector fetch wanted
    input wire logic [1:0] gap_i, // Extra idle cycles, slow mode
    output logic ack_o = 1'b0, // Fetch strobe
    output logic [3:0] ack_line_o = 4'h0, // Line served
    output logic reset_fetch_o = 1'b0 // Reset vector fetch
);
    int wait_n = 0;
    // One idle cycle at least, so a taken flag has left its line.
    // Bench levels are caught at the edge; the lines are read after
    // it, once the expander has updated them.
    always @(posedge clk_i) begin : serve
        logic boot;
        logic run;
        logic [1:0] gap;
        logic ack_v;
        logic rf_v;
        logic [3:0] line_v;
        boot = boot_i;
        run = run_i;
        gap = gap_i;
        #1;
        ack_v = 1'b0;
        rf_v = 1'b0;
        line_v = ack_line_o;
        if (wait_n > 0) begin
            wait_n--;
        end else if (boot) begin
            ack_v = 1'b1;
            rf_v = 1'b1;
            line_v = 4'h0;
            wait_n = 1;
        end else if (run && cpu_irq_i != 12'h000) begin
            for (int l = 11; l >= 0; l--)
                if (cpu_irq_i[l]) line_v = 4'(l);
            ack_v = 1'b1;
            wait_n = 1 + gap;
        end
        ack_o = ack_v;
        reset_fetch_o = rf_v;
        ack_line_o = line_v;
    end
endmodule

// file: sim/tb.sv
// Random traffic against a behavioural expander model
`timescale 1ns/10ps
module tb;
    logic clk_i = 0, rst_n_i = 0, vfe = 0, run = 0, boot = 0, ack, rf, ev, et;
    logic [95:0] src = 0, en = 0, set = 0, clr = 0, ef, flags, take;
    logic [11:0] irq, ei;
    logic [3:0] line;
    logic [1:0] gap = 0;
    logic [15:0] ea, a;
    logic [14:0] last, el;
    pie_map_pkg::vec_fetch_t fet;
    int errors = 0, n_compared = 0, k, g;
    always #2 clk_i = ~clk_i;
    pie_vector_group_mapping pie_vector_group_mapping_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .src_irq_i(src), .enable_i(en), .sw_set_i(set),
        .sw_clr_i(clr), .vector_fetch_enable_i(vfe), .ack_i(ack),
        .ack_line_i(line), .reset_fetch_i(rf), .cpu_irq_o(irq),
        .group_flag_register_o(flags), .fetch_o(fet),
        .last_vector_address_o(last));
    cpu_model cpu_model_i (.clk_i(clk_i), .cpu_irq_i(irq), .run_i(run),
        .boot_i(boot), .gap_i(gap), .ack_o(ack), .ack_line_o(line),
        .reset_fetch_o(rf));
    function automatic logic [95:0] rnd();
        return {$urandom, $urandom, $urandom};
    endfunction
    task automatic check(input string nm, input logic [95:0] e, s);
        n_compared++;
        if (e !== s) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Model: flags, lines and fetch settle one edge after inputs
    always @(posedge clk_i) begin
        take = 96'h0;
        k = -1;
        g = int'(line);
        for (int p = 7; p >= 0; p--)
            if (ef[8*g+p] && en[8*g+p]) k = 8 * g + p;
        if (ack && vfe && !rf && k >= 0) begin
            take[k] = 1'b1;
            a = pie_map_pkg::TABLE_BASE + 16'(2 * (32 + k));
            ea <= a;
            el <= a[15:1];
        end
        ef <= (ef & ~clr & ~take) | (src & pie_map_pkg::WIRED_MASK) | set;
        for (int i = 0; i < 12; i++) ei[i] <= |(ef[8*i+:8] & en[8*i+:8]);
        ev <= ack;
        et <= ack && vfe && !rf && k >= 0;
        if (!rst_n_i) begin
            {ef, ei, ev, et, el} <= '0;
        end
    end
    always @(negedge clk_i) begin
        check("irq", ei, irq);
        check("flags", ef, flags);
        check("valid", ev, fet.valid);
        check("table", et, fet.from_table);
        if (et) check("addr", ea, fet.addr);
        check("last", el, last);
    end
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
    // Phases: prompt, slow, table off, clears and boot, after reset
    initial begin
        void'($urandom(80427));
        repeat (4) @(posedge clk_i);
        #1 rst_n_i = 1;
        for (int ph = 0; ph < 5; ph++) begin
            en = rnd();
            vfe = ph != 2;
            run = ph != 3;
            gap = ph == 1 ? 2'h2 : 2'h0;
            repeat (200) begin
                @(posedge clk_i) #1;
                src = rnd() & rnd() & rnd();
                set = rnd() & rnd() & rnd() & ~pie_map_pkg::WIRED_MASK;
                clr = run ? 96'h0 : rnd() & rnd();
                boot = ph == 3 && $urandom % 8 == 0;
            end
            if (ph == 3) begin
                rst_n_i = 0;
                repeat (4) @(posedge clk_i);
                #1 rst_n_i = 1;
            end
        end
        report_and_stop();
    end
endmodule
